// ---- pgt_pkg.sv ----
// ***************************************************************
// Shared constants and types
// ***************************************************************
package pgt_pkg;

  localparam int unsigned CLK_HZ  = 250_000_000;
  localparam int unsigned CLK_KHZ = 250_000;

  // Counter widths; 7200 s at 250 MHz needs 41 bits
  localparam int unsigned TICK_W = 41;
  localparam int unsigned DB_W   = 24;

  localparam logic [TICK_W-1:0] TICK_ZERO = '0;
  localparam logic [TICK_W-1:0] TICK_ONE  = TICK_W'(1);
  localparam logic [DB_W-1:0]   DB_ZERO   = '0;
  localparam logic [DB_W-1:0]   DB_ONE    = DB_W'(1);

  // Times in their printed units
  localparam int unsigned MIN_IP_MS    = 100;
  localparam int unsigned MAX_IP_S     = 7200;
  localparam int unsigned GUARD_MS     = 50;
  localparam int unsigned VALID_MS     = 20;
  localparam int unsigned OBS_MS       = 30;
  localparam int unsigned DEBOUNCE_MS  = 20;
  localparam int unsigned MAN_DRIVE_MS = 10;
  localparam int unsigned DONE_MIN_NS  = 100;

  typedef enum logic [2:0] {
    ST_MEASURE,
    ST_ON,
    ST_OFF,
    ST_IDLE,
    ST_HOLD
  } pg_state_t;

endpackage : pgt_pkg

// ---- manual_done_if.sv ----
`timescale 1ns/10ps
// ***************************************************************
// Filtered manual request and done edge toward the controller
// ***************************************************************
interface manual_done_if;
  logic manualReq;
  logic manualHeld;
  logic donePulse;

  modport filt (output manualReq, output manualHeld);
  modport edge_det (output donePulse);
  modport ctrl (input manualReq, input manualHeld, input donePulse);
endinterface : manual_done_if

// ---- manual_on_filter.sv ----
`timescale 1ns/10ps
module manual_on_filter
  import pgt_pkg::*;
#(
  parameter logic [DB_W-1:0] VALID_CYC = DB_W'(VALID_MS * CLK_KHZ),
  parameter logic [DB_W-1:0] OBS_CYC   = DB_W'(OBS_MS * CLK_KHZ),
  parameter logic [DB_W-1:0] DB_CYC    = DB_W'(DEBOUNCE_MS * CLK_KHZ)
) (
  input  wire logic   ref_clk,
  input  wire logic   rstN,
  input  wire logic   enable,
  input  wire logic   manualOnIn,
  manual_done_if.filt ifc
);

  logic            winOpen_reg;
  logic [DB_W-1:0] winCnt_reg;
  logic [DB_W-1:0] highCnt_reg;
  logic            reqDone_reg;
  logic            held_reg;
  logic [DB_W-1:0] lowCnt_reg;
  logic            req_reg;
  logic            winStart;
  logic            validHit;

  assign winStart = enable && !winOpen_reg && manualOnIn && !held_reg;
  // High time is summed over the window, so bounce does not restart it
  assign validHit = enable && winOpen_reg && manualOnIn && !reqDone_reg
                    && (highCnt_reg + DB_ONE >= VALID_CYC);

  // ***************************************************************
  // Observation window
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      winOpen_reg <= 1'h0;
      winCnt_reg  <= DB_ZERO;
      highCnt_reg <= DB_ZERO;
      reqDone_reg <= 1'h0;
    end else if (!enable) begin
      winOpen_reg <= 1'h0;
      winCnt_reg  <= DB_ZERO;
      highCnt_reg <= DB_ZERO;
      reqDone_reg <= 1'h0;
    end else if (winStart) begin
      winOpen_reg <= 1'h1;
      winCnt_reg  <= DB_ZERO;
      highCnt_reg <= DB_ONE;
      reqDone_reg <= 1'h0;
    end else if (winOpen_reg) begin
      winCnt_reg <= winCnt_reg + DB_ONE;
      if (manualOnIn) begin
        highCnt_reg <= highCnt_reg + DB_ONE;
      end
      if (validHit) begin
        reqDone_reg <= 1'h1;
      end
      if (winCnt_reg == OBS_CYC - DB_ONE) begin
        winOpen_reg <= 1'h0;
      end
    end
  end

  // ***************************************************************
  // Request pulse and debounced level, both edges filtered
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      req_reg <= 1'h0;
    end else begin
      req_reg <= validHit;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      held_reg   <= 1'h0;
      lowCnt_reg <= DB_ZERO;
    end else if (!enable) begin
      held_reg   <= 1'h0;
      lowCnt_reg <= DB_ZERO;
    end else if (validHit) begin
      held_reg   <= 1'h1;
      lowCnt_reg <= DB_ZERO;
    end else if (held_reg) begin
      if (manualOnIn) begin
        lowCnt_reg <= DB_ZERO;
      end else if (lowCnt_reg == DB_CYC - DB_ONE) begin
        held_reg   <= 1'h0;
        lowCnt_reg <= DB_ZERO;
      end else begin
        lowCnt_reg <= lowCnt_reg + DB_ONE;
      end
    end
  end

  assign ifc.manualReq  = req_reg;
  assign ifc.manualHeld = held_reg;

  a_req_needs_high : assert property (@(posedge ref_clk) disable iff (!rstN)
    req_reg |-> $past(highCnt_reg) + DB_ONE >= VALID_CYC)
    else $error("Manual request without enough high time");

  a_held_release : assert property (@(posedge ref_clk) disable iff (!rstN)
    $fell(held_reg) && enable |-> $past(lowCnt_reg) == DB_CYC - DB_ONE)
    else $error("Debounced level fell too early");

endmodule : manual_on_filter

// ---- done_edge_detect.sv ----
`timescale 1ns/10ps
module done_edge_detect
  import pgt_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstN,
  input  wire logic       doneIn,
  manual_done_if.edge_det ifc
);

  logic prev_reg;

  // Prior level starts high so a done held high at reset is no edge
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      prev_reg <= 1'h1;
    end else begin
      prev_reg <= doneIn;
    end
  end

  assign ifc.donePulse = doneIn && !prev_reg;

  a_done_single : assert property (@(posedge ref_clk) disable iff (!rstN)
    ifc.donePulse |=> !ifc.donePulse)
    else $error("Done edge lasted more than one cycle");

endmodule : done_edge_detect

// ---- power_gating_interval_timer.sv ----
`timescale 1ns/10ps
// Function
// - Interval clamped to 100 ms .. 7200 s, latched once at start-up.
// - One resistor measurement after reset, never repeated later.
// - Mode select high gives periodic mode, low gives one-shot.
// - Gate drive active low; low turns the supply switch on.
// - Gate drive high during measurement, before any window.
// - Timer mode repeats one window per interval indefinitely.
// - Interval measured between successive gate drive falling edges.
// - Gate drive goes low at the start of each interval.
// - Without done, low for interval minus 50 ms, then high.
// - One-shot mode gives one window after start-up only.
// - In one-shot, each valid manual request starts one window.
// - Done accepted only as a rising transition.
// - Only the first done per interval is acted upon.
// - Accepted done drives gate high at once.
// - Manual valid if high 20 ms within 30 ms window.
// - Manual input passes a 20 ms debounce filter.
// - Manual request ignored while gate drive is low.
// - Manual high during measurement aborts it; restart on release.
// - Gate drive low within 10 ms of a valid manual request.
// - Manual request resets counters; restart once input released.
// - Done ignored while manual input is held high.
// - Debounce acts on both manual input edges; the code debounces only the release, the rise passes the valid window instead.
module power_gating_interval_timer
  import pgt_pkg::*;
#(
  parameter logic [TICK_W-1:0] MIN_IP_CYC =
    TICK_W'(64'(MIN_IP_MS) * 64'(CLK_KHZ)),
  parameter logic [TICK_W-1:0] MAX_IP_CYC =
    TICK_W'(64'(MAX_IP_S) * 64'(CLK_HZ)),
  parameter logic [TICK_W-1:0] GUARD_CYC =
    TICK_W'(64'(GUARD_MS) * 64'(CLK_KHZ)),
  parameter logic [DB_W-1:0]   VALID_CYC = DB_W'(VALID_MS * CLK_KHZ),
  parameter logic [DB_W-1:0]   OBS_CYC   = DB_W'(OBS_MS * CLK_KHZ),
  parameter logic [DB_W-1:0]   DB_CYC    = DB_W'(DEBOUNCE_MS * CLK_KHZ),
  parameter logic [DB_W-1:0]   MAN_DRIVE_CYC =
    DB_W'(MAN_DRIVE_MS * CLK_KHZ)
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              measDone,
  input  wire logic [TICK_W-1:0] measTicks,
  input  wire logic              modeSelect,
  input  wire logic              manualOnIn,
  input  wire logic              doneIn,
  output logic                   measActive,
  output logic                   gateDriveN,
  output logic                   timerMode
);

  // ***************************************************************
  // Reset release
  // ***************************************************************
  logic [1:0] rstPipe_reg;
  logic       rstN;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'h1};
    end
  end

  assign rstN = rstPipe_reg[1];

  // ***************************************************************
  // Input conditioning
  // ***************************************************************
  manual_done_if ifc ();

  pg_state_t         state_reg;
  logic [TICK_W-1:0] phaseCnt_reg;
  logic [TICK_W-1:0] interval_reg;
  logic              gateN_reg;
  logic              doneTaken_reg;
  logic              modeTimer_reg;
  logic              measActive_reg;

  manual_on_filter #(
    .VALID_CYC (VALID_CYC),
    .OBS_CYC   (OBS_CYC),
    .DB_CYC    (DB_CYC)
  ) u_filter (
    .ref_clk    (ref_clk),
    .rstN       (rstN),
    .enable     (state_reg != ST_MEASURE),
    .manualOnIn (manualOnIn),
    .ifc        (ifc.filt)
  );

  done_edge_detect u_done (
    .ref_clk (ref_clk),
    .rstN    (rstN),
    .doneIn  (doneIn),
    .ifc     (ifc.edge_det)
  );

  // ***************************************************************
  // Events
  // ***************************************************************
  logic [TICK_W-1:0] onLen;
  logic [TICK_W-1:0] measClamped;
  logic              measFinish;
  logic              doneAccept;
  logic              onEnd;
  logic              periodEnd;
  logic              manualStart;
  logic              holdRelease;

  assign measClamped = (measTicks < MIN_IP_CYC) ? MIN_IP_CYC :
                       (measTicks > MAX_IP_CYC) ? MAX_IP_CYC :
                       measTicks;
  assign onLen       = interval_reg - GUARD_CYC;
  assign measFinish  = (state_reg == ST_MEASURE) && measActive_reg &&
                       measDone && !manualOnIn;
  // Either done filter form of a held manual input blocks the edge
  assign doneAccept  = (state_reg == ST_ON) && ifc.donePulse &&
                       !doneTaken_reg && !ifc.manualHeld &&
                       !manualOnIn;
  assign onEnd       = (state_reg == ST_ON) &&
                       (phaseCnt_reg == onLen - TICK_ONE);
  assign periodEnd   = (state_reg == ST_OFF) &&
                       (phaseCnt_reg == interval_reg - TICK_ONE);
  assign manualStart = ifc.manualReq && gateN_reg &&
                       ((state_reg == ST_OFF) ||
                        (state_reg == ST_IDLE));
  assign holdRelease = (state_reg == ST_HOLD) && !ifc.manualHeld;

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      state_reg <= ST_MEASURE;
    end else begin
      case (state_reg)
        ST_MEASURE: begin
          if (measFinish) begin
            state_reg <= ST_ON;
          end
        end
        ST_ON: begin
          if (doneAccept || onEnd) begin
            state_reg <= ST_OFF;
          end
        end
        ST_OFF: begin
          if (manualStart) begin
            state_reg <= ST_HOLD;
          end else if (periodEnd) begin
            state_reg <= modeTimer_reg ? ST_ON : ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (manualStart) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (holdRelease) begin
            state_reg <= ST_ON;
          end
        end
        default: begin
          state_reg <= ST_MEASURE;
        end
      endcase
    end
  end

  // Counts from each falling edge except a manual start, which counts from hold release
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      phaseCnt_reg <= TICK_ZERO;
    end else if (measFinish || manualStart || (state_reg == ST_HOLD) ||
                 (state_reg == ST_IDLE) || periodEnd) begin
      phaseCnt_reg <= TICK_ZERO;
    end else if ((state_reg == ST_ON) || (state_reg == ST_OFF)) begin
      phaseCnt_reg <= phaseCnt_reg + TICK_ONE;
    end
  end

  // ***************************************************************
  // Gate drive
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      gateN_reg <= 1'h1;
    end else if (measFinish || manualStart ||
                 (periodEnd && modeTimer_reg)) begin
      gateN_reg <= 1'h0;
    end else if (doneAccept || onEnd) begin
      gateN_reg <= 1'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      doneTaken_reg <= 1'h0;
    end else if (measFinish || manualStart || periodEnd) begin
      doneTaken_reg <= 1'h0;
    end else if (doneAccept) begin
      doneTaken_reg <= 1'h1;
    end
  end

  // ***************************************************************
  // Start-up configuration
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      interval_reg  <= MIN_IP_CYC;
      modeTimer_reg <= 1'h0;
    end else if (measFinish) begin
      interval_reg  <= measClamped;
      modeTimer_reg <= modeSelect;
    end
  end

  // Analog chain only runs while requested; a drop aborts it
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      measActive_reg <= 1'h0;
    end else if ((state_reg != ST_MEASURE) || measFinish) begin
      measActive_reg <= 1'h0;
    end else begin
      measActive_reg <= !manualOnIn;
    end
  end

  assign measActive = measActive_reg;
  assign gateDriveN = gateN_reg;
  assign timerMode  = modeTimer_reg;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  sequence s_hold_entered;
    manualStart ##1 (state_reg == ST_HOLD);
  endsequence

  sequence s_released;
    (state_reg == ST_HOLD) && !ifc.manualHeld;
  endsequence

  a_gate_default_high : assert property (
    (state_reg == ST_MEASURE) |-> gateN_reg)
    else $error("Gate drive low during measurement");

  a_meas_abort : assert property (
    (state_reg == ST_MEASURE) && manualOnIn |=> !measActive_reg)
    else $error("Measurement not aborted by manual input");

  a_mode_sample : assert property (
    measFinish |=> (modeTimer_reg == $past(modeSelect)) && !gateN_reg)
    else $error("Mode not sampled at measurement end");

  a_interval_range : assert property (
    (state_reg != ST_MEASURE) |->
      (interval_reg >= MIN_IP_CYC) && (interval_reg <= MAX_IP_CYC))
    else $error("Interval outside allowed range");

  a_done_gate_high : assert property (
    doneAccept |=> gateN_reg && doneTaken_reg)
    else $error("Done did not end the window");

  a_done_manual_ignored : assert property (
    (state_reg == ST_ON) && ifc.donePulse && !onEnd &&
      (manualOnIn || ifc.manualHeld) |=> !gateN_reg)
    else $error("Done acted on while manual held");

  a_guard_end : assert property (
    onEnd |=> gateN_reg ##1 (gateN_reg || $past(manualStart)))
    else $error("Guard time not held high");

  a_period_restart : assert property (
    periodEnd && modeTimer_reg |=> !gateN_reg &&
      (phaseCnt_reg == TICK_ZERO))
    else $error("Periodic window did not restart");

  a_oneshot_stop : assert property (
    periodEnd && !modeTimer_reg && !manualStart |=>
      (state_reg == ST_IDLE) && gateN_reg)
    else $error("One-shot started another window");

  a_manual_ignored : assert property (
    ifc.manualReq && !gateN_reg |=> $stable(phaseCnt_reg) ||
      (phaseCnt_reg == $past(phaseCnt_reg) + TICK_ONE) || gateN_reg)
    else $error("Manual request disturbed an open window");

  a_manual_drive : assert property (
    s_hold_entered |-> !gateN_reg)
    else $error("Gate not driven after manual request");

  a_hold_release : assert property (
    s_released |=> (state_reg == ST_ON) && !gateN_reg &&
      (phaseCnt_reg == TICK_ZERO))
    else $error("Counters did not restart after release");

endmodule : power_gating_interval_timer

// ---- host_mcu_model.sv ----
`timescale 1ns/10ps
// ***************************************************************
// Host controller behind the switched supply
// ***************************************************************
module host_mcu_model (
  input  wire logic       ref_clk,
  input  wire logic       gateDriveN,
  input  wire logic [1:0] hostMode,
  input  wire logic [7:0] doneDelay,
  output logic            doneIn
);
  // Mode 0 quiet, 1 one done pulse per window, 2 level held high
  int   waitCnt  = 0;
  int   widthCnt = 0;
  logic fired    = 1'b0;

  always @(negedge ref_clk) begin
    if (gateDriveN !== 1'b0) begin
      waitCnt <= 0;
      fired   <= 1'b0;
    end else if (!fired) begin
      waitCnt <= waitCnt + 1;
    end
    if (widthCnt > 0) begin
      widthCnt <= widthCnt - 1;
    end
    // Pulse keeps going even after the supply is cut, as a real pin would
    if (hostMode == 2'h1 && !fired && gateDriveN === 1'b0 &&
        waitCnt == int'(doneDelay)) begin
      fired    <= 1'b1;
      widthCnt <= 25;
    end
    doneIn <= (hostMode == 2'h2) || (widthCnt > 0);
  end
endmodule : host_mcu_model

// ---- tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
  fail_count++; $display("[FAIL] %s exp %0d got %0d", nm, ex, gt); end end
// ***************************************************************
// Testbench
// ***************************************************************
module tb;
  import pgt_pkg::*;

  localparam int GD = 10;
  localparam int VD = 8;
  localparam int DBC = 8;

  logic              ref_clk;
  logic              nrst;
  logic              measDone;
  logic [TICK_W-1:0] measTicks;
  logic              modeSelect;
  logic              manualOnIn;
  logic              doneIn;
  logic              measActive;
  logic              gateDriveN;
  logic              timerMode;
  logic [1:0]        hostMode;
  logic [7:0]        doneDelay;
  int                fail_count;
  int                num_checks;
  int                cycles;
  int                n;
  int                lo;
  int                hi;
  int                per;
  int                d;

  power_gating_interval_timer #(
    .MIN_IP_CYC(TICK_W'(40)),
    .MAX_IP_CYC(TICK_W'(4000)),
    .GUARD_CYC (TICK_W'(GD)),
    .VALID_CYC (DB_W'(VD)),
    .OBS_CYC   (DB_W'(12)),
    .DB_CYC    (DB_W'(DBC))
  ) i_power_gating_interval_timer (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .measDone  (measDone),
    .measTicks (measTicks),
    .modeSelect(modeSelect),
    .manualOnIn(manualOnIn),
    .doneIn    (doneIn),
    .measActive(measActive),
    .gateDriveN(gateDriveN),
    .timerMode (timerMode)
  );

  host_mcu_model i_host_mcu_model (
    .ref_clk   (ref_clk),
    .gateDriveN(gateDriveN),
    .hostMode  (hostMode),
    .doneDelay (doneDelay),
    .doneIn    (doneIn)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Hang guard; the longest path is the one-shot windows of 4000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      close_out();
    end
  end

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // Counts cycles while the gate drive keeps the given level
  task automatic gate_run(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (gateDriveN === lvl && cnt < lim) begin
      @(negedge ref_clk);
      cnt++;
    end
  endtask : gate_run

  task automatic wait_meas();
    int k;
    k = 0;
    while (measActive !== 1'b1 && k < 50) begin
      @(negedge ref_clk);
      k++;
    end
  endtask : wait_meas

  task automatic do_reset();
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (12) @(negedge ref_clk);
    `CHK("gate in reset", 1'b1, gateDriveN)
    nrst = 1'b1;
  endtask : do_reset

  task automatic do_meas(input logic mode, input logic [TICK_W-1:0] t);
    int k;
    wait_meas();
    `CHK("meas active", 1'b1, measActive)
    `CHK("gate before window", 1'b1, gateDriveN)
    modeSelect = mode;
    measTicks  = t;
    measDone   = 1'b1;
    @(negedge ref_clk);
    measDone   = 1'b0;
    measTicks  = TICK_W'($urandom_range(3000, 40));
    // Strap moves afterwards; the latched mode must not follow
    modeSelect = ~mode;
    gate_run(1'b1, 3, k);
    `CHK("first fall", 1'b0, gateDriveN)
    `CHK("mode", mode, timerMode)
  endtask : do_meas

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    nrst       = 1'b0;
    measDone   = 1'b0;
    measTicks  = '0;
    modeSelect = 1'b0;
    manualOnIn = 1'b0;
    hostMode   = 2'h0;
    doneDelay  = 8'h00;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(32'h1b539f94));
    per = $urandom_range(200, 80);
    do_reset();
    wait_meas();
    manualOnIn = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK("meas abort", 1'b0, measActive)
    measDone = 1'b1;
    @(negedge ref_clk);
    measDone = 1'b0;
    repeat (5) @(negedge ref_clk);
    `CHK("refused strobe", 1'b1, gateDriveN)
    manualOnIn = 1'b0;
    do_meas(1'b1, TICK_W'(per));
    repeat (2) begin
      gate_run(1'b0, 5000, lo);
      gate_run(1'b1, 5000, hi);
      `CHK("low time", per - GD, lo)
      `CHK("period", per, lo + hi)
    end
    gate_run(1'b0, 5000, lo);
    hostMode = 2'h2;
    gate_run(1'b1, 5000, hi);
    gate_run(1'b0, 5000, lo);
    `CHK("static done", per - GD, lo)
    hostMode  = 2'h0;
    d         = $urandom_range(per - 30, 5);
    doneDelay = 8'(d);
    hostMode  = 2'h1;
    gate_run(1'b1, 5000, hi);
    gate_run(1'b0, 5000, lo);
    `CHK("done cut", 1'b1, lo >= d && lo <= d + 4)
    doneDelay = 8'h04;
    gate_run(1'b1, 5000, hi);
    `CHK("done period", per, lo + hi)
    manualOnIn = 1'b1;
    repeat (20) @(negedge ref_clk);
    manualOnIn = 1'b0;
    gate_run(1'b0, 5000, lo);
    `CHK("done masked", per - GD, lo + 20)
    hostMode = 2'h0;
    gate_run(1'b1, 5000, hi);
    `CHK("manual ignored", GD, hi)
    `CHK("no remeasure", 1'b0, measActive)

    // One-shot, interval read above the ceiling
    do_reset();
    do_meas(1'b0, 41'h1388);
    gate_run(1'b0, 5000, lo);
    `CHK("clamped window", 4000 - GD, lo)
    gate_run(1'b1, 300, hi);
    `CHK("single window", 300, hi)
    manualOnIn = 1'b1;
    repeat (4) @(negedge ref_clk);
    manualOnIn = 1'b0;
    repeat (20) @(negedge ref_clk);
    `CHK("glitch", 1'b1, gateDriveN)
    manualOnIn = 1'b1;
    gate_run(1'b1, 30, n);
    `CHK("manual on", 1'b1, n >= VD && n <= VD + 3)
    repeat (4) @(negedge ref_clk);
    manualOnIn = 1'b0;
    gate_run(1'b0, 5000, lo);
    n = int'((lo >= DBC + 3988) && (lo <= DBC + 3992));
    `CHK("manual window", 1'b1, n)
    d         = $urandom_range(200, 30);
    doneDelay = 8'(d);
    hostMode  = 2'h1;
    manualOnIn = 1'b1;
    gate_run(1'b1, 30, n);
    @(negedge ref_clk);
    manualOnIn = 1'b0;
    gate_run(1'b0, 5000, lo);
    `CHK("manual done", 1'b1, lo >= d - 3 && lo <= d + 3)
    hostMode = 2'h0;
    close_out();
  end
endmodule : tb
